// ### pkg/ctt_pkg.sv
// constants shared by the compressor run-on timer block
package ctt_pkg;
    // timeout field layout: minutes and seconds, each 0..59
    localparam int MIN_W = 6;
    localparam int SEC_W = 6;
    localparam logic [MIN_W-1:0] MAX_MIN = 6'h3B;
    localparam logic [SEC_W-1:0] MAX_SEC = 6'h3B;
    // remaining count in seconds, 59:59 is 3599
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    // one-second tick from the 100 MHz core clock
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYC = CLK_HZ * TICK_S;
    localparam int TICK_W = 27;
    localparam int CH_N = 2;
endpackage

// ### hdl/ctt_tick_gen.sv
// one-second tick generator for the run-on timer
`timescale 1ns/10ps
module ctt_tick_gen #(
    parameter int TICK_CYC = ctt_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    output logic tick
);
    import ctt_pkg::*;

    logic [TICK_W-1:0] div_ff;
    logic tick_ff;

    // free-running divider, one pulse per period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == TICK_W'(TICK_CYC - 1)) begin
            div_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + TICK_W'(1);
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;
endmodule

// ### hdl/ctt_top.sv
// compressor run-on timer and combined alarm output
`timescale 1ns/10ps
module ctt_top #(
    parameter int TICK_CYC = ctt_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ctt_pkg::MIN_W-1:0] ch1_timeout_min,
    input wire logic [ctt_pkg::SEC_W-1:0] ch1_timeout_sec,
    input wire logic [ctt_pkg::MIN_W-1:0] ch2_timeout_min,
    input wire logic [ctt_pkg::SEC_W-1:0] ch2_timeout_sec,
    input wire logic ch1_decrease,
    input wire logic ch2_decrease,
    input wire logic ch1_dev_alarm,
    input wire logic ch1_sp_alarm,
    input wire logic ch2_dev_alarm,
    input wire logic ch2_sp_alarm,
    output logic compressor_timeout_n,
    output logic alarm_out,
    output logic timer_running
);
    import ctt_pkg::*;

    logic tick;
    logic [CH_N-1:0] dec_raw;
    logic [CH_N-1:0] dec_s1_ff;
    logic [CH_N-1:0] dec_s2_ff;
    logic [CH_N-1:0] dec_d_ff;
    logic [CH_N-1:0] dec_end;
    logic [CNT_W-1:0] ch_load [CH_N];
    logic [CH_N-1:0] ch_en;
    logic [3:0] alm_s1_ff;
    logic [3:0] alm_s2_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic out_n_ff;
    logic alarm_ff;

    ctt_tick_gen #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    assign dec_raw = {ch2_decrease, ch1_decrease};

    // decrease pulses come from the control loop pins: two-stage sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_s1_ff <= '0;
            dec_s2_ff <= '0;
            dec_d_ff <= '0;
        end else begin
            dec_s1_ff <= dec_raw;
            dec_s2_ff <= dec_s1_ff;
            dec_d_ff <= dec_s2_ff;
        end
    end

    // per channel: load value in seconds, clamp fields to 59
    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        logic [MIN_W-1:0] m;
        logic [SEC_W-1:0] s;
        assign m = (i == 0) ? ch1_timeout_min : ch2_timeout_min;
        assign s = (i == 0) ? ch1_timeout_sec : ch2_timeout_sec;
        assign ch_load[i] = CNT_W'((m > MAX_MIN ? MAX_MIN : m) * 60)
            + CNT_W'(s > MAX_SEC ? MAX_SEC : s);
        // zero timeout drops the channel out of the shared timer
        assign ch_en[i] = (ch_load[i] != CNT_ZERO);
        // falling edge marks the end of a decrease pulse
        assign dec_end[i] = dec_d_ff[i] & ~dec_s2_ff[i] & ch_en[i];
    end

    // reload wins over tick; channel two wins a same-cycle tie
    always_comb begin
        nxt_cnt = cnt_ff;
        if (dec_end[1]) begin
            nxt_cnt = ch_load[1];
        end else if (dec_end[0]) begin
            nxt_cnt = ch_load[0];
        end else if (tick && cnt_ff != CNT_ZERO) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
        end
    end

    // countdown state, idle at reset so the output starts released
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= CNT_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // output low while count is nonzero, high once it runs out
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_n_ff <= 1'b1;
        end else begin
            out_n_ff <= (nxt_cnt == CNT_ZERO);
        end
    end

    // alarm inputs are asynchronous status lines: sync then merge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alm_s1_ff <= '0;
            alm_s2_ff <= '0;
            alarm_ff <= 1'b0;
        end else begin
            alm_s1_ff <= {ch2_sp_alarm, ch2_dev_alarm,
                ch1_sp_alarm, ch1_dev_alarm};
            alm_s2_ff <= alm_s1_ff;
            alarm_ff <= |alm_s2_ff;
        end
    end

    assign compressor_timeout_n = out_n_ff;
    assign alarm_out = alarm_ff;
    assign timer_running = ~out_n_ff; // inverse of the timeout output
endmodule

// ### sim/ctt_contactor.sv
// contactor model switched by the active-low timeout output
`timescale 1ns/10ps
module ctt_contactor (
    input wire logic core_clk,
    input wire logic coil_n,
    output logic energized
);
    // coil pulls in one clock after the drive goes low, no latch-up
    always_ff @(posedge core_clk) energized <= !coil_n;
endmodule

// ### sim/ctt_top_sva.sv
// port checker for the compressor run-on timer
`timescale 1ns/10ps
module ctt_top_sva import ctt_pkg::*; (
    input wire logic core_clk, rst_n, ch1_decrease, ch2_decrease,
    input wire logic [MIN_W-1:0] ch1_timeout_min, ch2_timeout_min,
    input wire logic [SEC_W-1:0] ch1_timeout_sec, ch2_timeout_sec,
    input wire logic ch1_dev_alarm, ch1_sp_alarm, ch2_dev_alarm,
    input wire logic ch2_sp_alarm, compressor_timeout_n, alarm_out,
    input wire logic timer_running
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // a channel whose fields are both zero is switched off
    wire z1 = (ch1_timeout_min | ch1_timeout_sec) == 6'h00;
    wire z2 = (ch2_timeout_min | ch2_timeout_sec) == 6'h00;
    wire any_al = ch1_dev_alarm | ch1_sp_alarm | ch2_dev_alarm | ch2_sp_alarm;
    sequence s_quiet;
        (!ch1_decrease && !ch2_decrease)[*6];
    endsequence
    a_alarm_merge: assert property (alarm_out == $past(any_al, 3))
        else $error("alarm output not the merge of alarms");
    a_run_flag: assert property (timer_running == !compressor_timeout_n)
        else $error("running flag disagrees with timeout output");
    a_ch1_load: assert property ($fell(ch1_decrease) && !z1 |->
        ##[2:5] !compressor_timeout_n) else $error("channel one no load");
    a_ch2_load: assert property ($fell(ch2_decrease) && !z2 |->
        ##[2:5] !compressor_timeout_n) else $error("channel two no load");
    a_zero_off: assert property (compressor_timeout_n && z1 && z2 |=>
        compressor_timeout_n) else $error("disabled channels started timer");
    a_quiet_idle: assert property (s_quiet ##0 compressor_timeout_n |=>
        compressor_timeout_n) else $error("timer started with no pulse");
    a_reset_idle: assert property ($past(!rst_n) |->
        compressor_timeout_n && !alarm_out) else $error("not idle after reset");
    // the bench never sets a timeout under two seconds
    a_low_min: assert property ($fell(compressor_timeout_n) |->
        !compressor_timeout_n[*8]) else $error("timeout released too early");
endmodule

// ### sim/test_compressor_timeout_timer.sv
// self-checking bench for the compressor run-on timer
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
    $display("ERROR %s exp %b got %b", n, e, s); end end
module test_compressor_timeout_timer;
    import ctt_pkg::*;
    logic core_clk = 0, rst_n = 0, d1 = 0, d2 = 0, energized, to_n, alm, run;
    logic [MIN_W-1:0] m1 = 6'h00, m2 = 6'h00;
    logic [SEC_W-1:0] s1 = 6'h02, s2 = 6'h04;
    logic [3:0] al = 4'h0;
    int fails = 0, n_compared = 0;
    always #5 core_clk = ~core_clk;
    // ten-cycle tick keeps a second short; timeouts are 20 and 40 cycles
    ctt_top #(.TICK_CYC(10)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .ch1_timeout_min(m1), .ch1_timeout_sec(s1), .ch2_timeout_min(m2),
        .ch2_timeout_sec(s2), .ch1_decrease(d1), .ch2_decrease(d2),
        .ch1_dev_alarm(al[0]), .ch1_sp_alarm(al[1]), .ch2_dev_alarm(al[2]),
        .ch2_sp_alarm(al[3]), .compressor_timeout_n(to_n), .alarm_out(alm),
        .timer_running(run));
    ctt_contactor cont_u (.core_clk(core_clk), .coil_n(to_n),
        .energized(energized));
    task automatic wait_n(int n); repeat (n) @(negedge core_clk); endtask
    // decrease pulse of four cycles, its falling end is what counts
    task automatic pulse(bit ch);
        if (ch) d2 = 1; else d1 = 1; wait_n(4); d1 = 0; d2 = 0;
    endtask
    task automatic t_single;
        pulse(0); wait_n(5); `CHK("run", 1'b1, run)
        `CHK("contactor", 1'b1, energized)
        wait_n(5); `CHK("timeout_n", 1'b0, to_n)
        wait_n(16); `CHK("timeout_n", 1'b1, to_n)
    endtask
    task automatic t_reload;
        // look past where a two-second reload would end, before four would
        pulse(0); wait_n(10); pulse(1); wait_n(30);
        `CHK("timeout_n", 1'b0, to_n)
        wait_n(16); `CHK("timeout_n", 1'b1, to_n)
    endtask
    task automatic t_zero;
        s2 = 6'h00; pulse(1); wait_n(8); `CHK("timeout_n", 1'b1, to_n)
        s1 = 6'h00; pulse(0); wait_n(8); `CHK("timeout_n", 1'b1, to_n)
        s1 = 6'h02; s2 = 6'h04;
    endtask
    task automatic t_alarm;
        for (int i = 0; i < 4; i++) begin
            al = 4'h1 << i; wait_n(5); `CHK("alarm", 1'b1, alm)
            al = 4'h0; wait_n(5); `CHK("alarm", 1'b0, alm)
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        wait_n(16); rst_n = 1; wait_n(2);
        `CHK("timeout_n", 1'b1, to_n)
        t_single(); t_reload(); t_zero(); t_alarm(); end_of_test();
    end
    // a run of about 180 cycles; a hang is cut off far beyond that
    initial begin
        #20000; fails++; end_of_test();
    end
endmodule
bind ctt_top ctt_top_sva chk_u (.*);
